// file: hw/sfs_defines.vh
`ifndef SFS_DEFINES_VH
`define SFS_DEFINES_VH

// command opcodes
`define SFS_OP_READ_STATUS    8'h05
`define SFS_OP_WRITE_STATUS1  8'h01
// no opcode is known for the byte 2 write; the top module takes it as a
// parameter whose default is this value
`define SFS_OP_WRITE_STATUS2  8'h31

// status byte 1 field positions
`define SFS_B1_LOCK_BIT       7
`define SFS_B1_RES_BIT        6
`define SFS_B1_ERR_BIT        5
`define SFS_B1_WPP_BIT        4
`define SFS_B1_SWP_HI         3
`define SFS_B1_SWP_LO         2
`define SFS_B1_WEL_BIT        1
`define SFS_B1_BUSY_BIT       0

// status byte 2 field positions
`define SFS_B2_RES_HI         7
`define SFS_B2_RES_LO         5
`define SFS_B2_RESET_COMMAND_ENABLE_BIT       4
`define SFS_B2_SLE_BIT        3
`define SFS_B2_PS_BIT         2
`define SFS_B2_ES_BIT         1
`define SFS_B2_BUSY_BIT       0

// global protect code carried in the byte 1 write data
`define SFS_GP_HI             5
`define SFS_GP_LO             2

// reset values
`define SFS_RST_LOCK          1'b0
`define SFS_RST_RESET_COMMAND_ENABLE          1'b0
`define SFS_RST_SLE           1'b0
`define SFS_RST_ERR           1'b0
`define SFS_RES_VALUE         1'b0

// synchroniser depth for pins
`define SFS_SYNC_STAGES       2

`endif

// file: hw/sfs_sync.v
`timescale 1ns/1ns
module sfs_sync #(
   parameter WIDTH = 4
) (
   input  wire             clk,
   input  wire             reset,
   input  wire [WIDTH-1:0] async_in,
   input  wire [WIDTH-1:0] rst_val,
   output wire [WIDTH-1:0] sync_out
);
   // two flops per pin; the first stage feeds only the second
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         reg meta_r;
         reg stab_r;
         always @(posedge clk) begin
            if (reset) begin
               meta_r <= rst_val[i];
               stab_r <= rst_val[i];
            end else begin
               meta_r <= async_in[i];
               stab_r <= meta_r;
            end
         end
         // reset loads each pin's idle level, so no false edge follows it
         assign sync_out[i] = stab_r;
      end
   endgenerate

endmodule

// file: hw/sfs_tx_shift.v
`timescale 1ns/1ns
module sfs_tx_shift (
   input  wire       clk,
   input  wire       reset,
   input  wire       load,
   input  wire       shift,
   input  wire       clear,
   input  wire [7:0] load_byte,
   output wire       bit_out
);
   reg [7:0] shreg_r;
   reg [7:0] shreg_nxt;

   // load wins over shift so a fresh byte is never shifted early
   always @* begin
      shreg_nxt = shreg_r;
      if (clear) begin
         shreg_nxt = 8'h00;
      end else if (load) begin
         shreg_nxt = load_byte;
      end else if (shift) begin
         shreg_nxt = {shreg_r[6:0], 1'b0};
      end
   end

   always @(posedge clk) begin
      if (reset) begin
         shreg_r <= 8'h00;
      end else begin
         shreg_r <= shreg_nxt;
      end
   end

   // msb leaves first, straight from the flop
   assign bit_out = shreg_r[7];

endmodule

// file: hw/sfs_status_reg.v
`timescale 1ns/1ns
`include "sfs_defines.vh"
module sfs_status_reg #(
   parameter [7:0] OP_WRITE2 = `SFS_OP_WRITE_STATUS2
) (
   input  wire       mclk,
   input  wire       reset,
   input  wire       spi_sclk,
   input  wire       spi_cs_n,
   input  wire       spi_si,
   output wire       spi_so,
   output wire       spi_so_oe,
   input  wire       wp_n,
   input  wire       busy,
   input  wire       write_enable_latch,
   input  wire [1:0] software_protection_summary,
   input  wire       program_suspended,
   input  wire       erase_suspended,
   input  wire       op_done,
   input  wire       op_fail,
   input  wire       op_aborted,
   input  wire       sector_prot_req,
   output wire       sector_prot_grant,
   output wire       global_prot_go,
   output wire [3:0] global_prot_code,
   output wire       status_write_end,
   output wire       protection_lock,
   output wire       reset_command_enable,
   output wire       lockdown_enable,
   output wire       program_erase_error
);
   // command states
   localparam [2:0] ST_OPCODE = 3'd0;
   localparam [2:0] ST_READ   = 3'd1;
   localparam [2:0] ST_WRITE1 = 3'd2;
   localparam [2:0] ST_WRITE2 = 3'd3;
   localparam [2:0] ST_IGNORE = 3'd4;

   wire [3:0] pins_s;
   wire       sclk_s;
   wire       cs_n_s;
   wire       si_s;
   wire       wp_n_s;
   wire       tx_bit;

   reg        sclk_d_r;
   reg        cs_n_d_r;
   reg  [2:0] state_r;
   reg  [2:0] state_nxt;
   reg  [2:0] rx_cnt_r;
   reg  [2:0] rx_cnt_nxt;
   reg  [7:0] rx_sh_r;
   reg  [7:0] rx_sh_nxt;
   reg  [7:0] wdata_r;
   reg  [7:0] wdata_nxt;
   reg        got_byte_r;
   reg        got_byte_nxt;
   reg  [2:0] tx_cnt_r;
   reg  [2:0] tx_cnt_nxt;
   reg        tx_sel_r;
   reg        tx_sel_nxt;
   reg        oe_r;
   reg        oe_nxt;
   reg        lock_r;
   reg        lock_nxt;
   reg        reset_command_enable_r;
   reg        reset_command_enable_nxt;
   reg        sle_r;
   reg        sle_nxt;
   reg        err_r;
   reg        grant_r;
   reg        gp_go_r;
   reg        gp_go_nxt;
   reg  [3:0] gp_code_r;
   reg  [3:0] gp_code_nxt;
   reg        wr_end_r;
   reg        wr_end_nxt;

   wire       sclk_rise;
   wire       sclk_fall;
   wire       cs_active;
   wire       cs_release;
   wire [7:0] rx_byte;
   wire [7:0] status_one;
   wire [7:0] status_two;
   wire [7:0] tx_byte;
   wire       tx_load;
   wire       tx_shift;
   wire       write_ok;

   // pins enter through two flops; select and protect idle high
   sfs_sync #(
      .WIDTH    (4)
   ) u_sync (
      .clk      (mclk),
      .reset    (reset),
      .async_in ({wp_n, spi_si, ~spi_cs_n, spi_sclk}),
      .rst_val  (4'h8), // protect pin idles high; inverted select and the rest low
      .sync_out (pins_s)
   );

   assign sclk_s = pins_s[0];
   assign cs_n_s = ~pins_s[1];
   assign si_s   = pins_s[2];
   assign wp_n_s = pins_s[3];

   // edge finders look only at the settled copies
   always @(posedge mclk) begin
      if (reset) begin
         sclk_d_r <= 1'b0;
         cs_n_d_r <= 1'b1;
      end else begin
         sclk_d_r <= sclk_s;
         cs_n_d_r <= cs_n_s;
      end
   end

   assign cs_active  = ~cs_n_s;
   assign sclk_rise  = cs_active & sclk_s & ~sclk_d_r;
   assign sclk_fall  = cs_active & ~sclk_s & sclk_d_r;
   assign cs_release = cs_n_s & ~cs_n_d_r;

   // byte assembled including the bit arriving on this edge
   assign rx_byte = {rx_sh_r[6:0], si_s};

   // live status pictures, rebuilt from current state every cycle
   assign status_one = {lock_r,
                        `SFS_RES_VALUE,
                        err_r,
                        wp_n_s,
                        software_protection_summary,
                        write_enable_latch,
                        busy};
   assign status_two = {{3{`SFS_RES_VALUE}},
                        reset_command_enable_r,
                        sle_r,
                        program_suspended,
                        erase_suspended,
                        busy};

   // pick the byte to start; sampled at the start of each byte
   assign tx_byte  = tx_sel_r ? status_two : status_one;
   assign tx_load  = (state_r == ST_READ) & sclk_fall & (tx_cnt_r == 3'd0);
   assign tx_shift = (state_r == ST_READ) & sclk_fall & (tx_cnt_r != 3'd0);

   // output flop changes on falling sclk, msb first, and is cleared at release
   sfs_tx_shift u_tx (
      .clk       (mclk),
      .reset     (reset),
      .load      (tx_load),
      .shift     (tx_shift),
      .clear     (cs_release),
      .load_byte (tx_byte),
      .bit_out   (tx_bit)
   );

   // writes count only as a whole byte ending on a byte boundary
   assign write_ok = got_byte_r & (rx_cnt_r == 3'd0) & write_enable_latch;

   // command decode, receive path and transmit counters
   always @* begin
      state_nxt    = state_r;
      rx_cnt_nxt   = rx_cnt_r;
      rx_sh_nxt    = rx_sh_r;
      wdata_nxt    = wdata_r;
      got_byte_nxt = got_byte_r;
      tx_cnt_nxt   = tx_cnt_r;
      tx_sel_nxt   = tx_sel_r;
      oe_nxt       = oe_r;
      if (cs_n_s) begin
         // release ends any command mid-byte, no error kept
         state_nxt    = ST_OPCODE;
         rx_cnt_nxt   = 3'd0;
         got_byte_nxt = 1'b0;
         tx_cnt_nxt   = 3'd0;
         tx_sel_nxt   = 1'b0;
         oe_nxt       = 1'b0;
      end else begin
         if (sclk_rise) begin
            rx_sh_nxt  = rx_byte;
            rx_cnt_nxt = rx_cnt_r + 3'd1;
         end
         case (state_r)
            ST_OPCODE: begin
               if (sclk_rise && rx_cnt_r == 3'd7) begin
                  // busy does not gate the status read
                  if (rx_byte == `SFS_OP_READ_STATUS) begin
                     state_nxt = ST_READ;
                  end else if (rx_byte == `SFS_OP_WRITE_STATUS1) begin
                     state_nxt = ST_WRITE1;
                  end else if (rx_byte == OP_WRITE2) begin
                     state_nxt = ST_WRITE2;
                  end else begin
                     state_nxt = ST_IGNORE;
                  end
               end
            end
            ST_READ: begin
               if (sclk_fall) begin
                  // first falling edge after the opcode drives bit 7
                  oe_nxt     = 1'b1;
                  tx_cnt_nxt = tx_cnt_r + 3'd1;
                  if (tx_cnt_r == 3'd7) begin
                     tx_sel_nxt = ~tx_sel_r;
                  end
               end
            end
            ST_WRITE1, ST_WRITE2: begin
               // keep the first data byte; later bytes are ignored
               if (sclk_rise && rx_cnt_r == 3'd7 && !got_byte_r) begin
                  wdata_nxt    = rx_byte;
                  got_byte_nxt = 1'b1;
               end
            end
            ST_IGNORE: begin
               state_nxt = ST_IGNORE;
            end
            default: begin
               state_nxt = ST_OPCODE;
            end
         endcase
      end
   end

   // writable bits: applied when select releases
   always @* begin
      lock_nxt    = lock_r;
      reset_command_enable_nxt    = reset_command_enable_r;
      sle_nxt     = sle_r;
      gp_go_nxt   = 1'b0;
      gp_code_nxt = gp_code_r;
      wr_end_nxt  = 1'b0;
      if (cs_release && write_enable_latch &&
          (state_r == ST_WRITE1 || state_r == ST_WRITE2)) begin
         // complete or aborted, the latch owner is told the write ended
         wr_end_nxt = 1'b1;
      end
      if (cs_release && write_ok && state_r == ST_WRITE1) begin
         // pin asserted: a lock may be set but never cleared
         if (wp_n_s || !lock_r || wdata_r[`SFS_B1_LOCK_BIT]) begin
            lock_nxt = wdata_r[`SFS_B1_LOCK_BIT];
         end
         // global protect follows the lock state before this write
         if (!lock_r) begin
            gp_go_nxt   = 1'b1;
            gp_code_nxt = wdata_r[`SFS_GP_HI:`SFS_GP_LO];
         end
      end
      if (cs_release && write_ok && state_r == ST_WRITE2) begin
         reset_command_enable_nxt = wdata_r[`SFS_B2_RESET_COMMAND_ENABLE_BIT];
         sle_nxt  = wdata_r[`SFS_B2_SLE_BIT];
      end
   end

   // control flops; no soft reset input reaches lock, reset_command_enable or sle
   always @(posedge mclk) begin
      if (reset) begin
         state_r    <= ST_OPCODE;
         rx_cnt_r   <= 3'd0;
         rx_sh_r    <= 8'h00;
         wdata_r    <= 8'h00;
         got_byte_r <= 1'b0;
         tx_cnt_r   <= 3'd0;
         tx_sel_r   <= 1'b0;
         oe_r       <= 1'b0;
         lock_r     <= `SFS_RST_LOCK;
         reset_command_enable_r     <= `SFS_RST_RESET_COMMAND_ENABLE;
         sle_r      <= `SFS_RST_SLE;
         gp_go_r    <= 1'b0;
         gp_code_r  <= 4'h0;
         wr_end_r   <= 1'b0;
      end else begin
         state_r    <= state_nxt;
         rx_cnt_r   <= rx_cnt_nxt;
         rx_sh_r    <= rx_sh_nxt;
         wdata_r    <= wdata_nxt;
         got_byte_r <= got_byte_nxt;
         tx_cnt_r   <= tx_cnt_nxt;
         tx_sel_r   <= tx_sel_nxt;
         oe_r       <= oe_nxt;
         lock_r     <= lock_nxt;
         reset_command_enable_r     <= reset_command_enable_nxt;
         sle_r      <= sle_nxt;
         gp_go_r    <= gp_go_nxt;
         gp_code_r  <= gp_code_nxt;
         wr_end_r   <= wr_end_nxt;
      end
   end

   // error flag rewritten by every finished operation; aborts clear it
   always @(posedge mclk) begin
      if (reset) begin
         err_r <= `SFS_RST_ERR;
      end else if (op_done) begin
         err_r <= op_fail & ~op_aborted;
      end
   end

   // sector protect requests pass only while unlocked
   always @(posedge mclk) begin
      if (reset) begin
         grant_r <= 1'b0;
      end else begin
         grant_r <= sector_prot_req & ~lock_r;
      end
   end

   // pin output straight from the shift flop; enable drops at release
   assign spi_so               = tx_bit;
   assign spi_so_oe            = oe_r;
   assign sector_prot_grant    = grant_r;
   assign global_prot_go       = gp_go_r;
   assign global_prot_code     = gp_code_r;
   assign status_write_end     = wr_end_r;
   assign protection_lock      = lock_r;
   assign reset_command_enable = reset_command_enable_r;
   assign lockdown_enable      = sle_r;
   assign program_erase_error  = err_r;

endmodule

// file: dv/sfs_monitor.sv
`timescale 1ns/1ns
module sfs_monitor (
   input wire       mclk,
   input wire       reset,
   input wire       spi_sclk,
   input wire       spi_cs_n,
   input wire       spi_so,
   input wire       spi_so_oe,
   input wire       wp_n,
   input wire       op_done,
   input wire       op_fail,
   input wire       op_aborted,
   input wire       sector_prot_req,
   input wire       sector_prot_grant,
   input wire       protection_lock,
   input wire       program_erase_error
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   // four samples cover the two pin flops plus the output register
   sequence cs_idle; spi_cs_n [*4]; endsequence
   sequence cs_busy; !spi_cs_n [*4]; endsequence
   sequence bad_op; op_done && op_fail && !op_aborted; endsequence
   sequence good_op; op_done && (op_aborted || !op_fail); endsequence
   a_grant_open: assert property (
      sector_prot_req && !protection_lock |=> sector_prot_grant)
      else $error("sector grant missing while unlocked");
   a_grant_cause: assert property (
      sector_prot_grant |-> $past(sector_prot_req) && !$past(protection_lock))
      else $error("sector grant without unlocked request");
   a_error_set: assert property (
      bad_op |=> program_erase_error)
      else $error("error flag not set after failed operation");
   a_error_clear: assert property (
      good_op |=> !program_erase_error)
      else $error("error flag set after clean or aborted operation");
   a_error_hold: assert property (
      !op_done && !$past(op_done) |=> $stable(program_erase_error))
      else $error("error flag moved without an operation");
   a_lock_pin: assert property (
      $fell(protection_lock) |->
         wp_n || $past(wp_n) || $past(wp_n, 2) || $past(wp_n, 3))
      else $error("lock cleared while protect pin held");
   a_lock_still: assert property (
      cs_busy |-> $stable(protection_lock))
      else $error("lock changed inside a frame");
   a_oe_release: assert property (
      cs_idle |-> !spi_so_oe)
      else $error("output still driven after deselect");
   a_so_fall: assert property (
      spi_so_oe && $past(spi_so_oe) && $changed(spi_so) |-> !spi_sclk)
      else $error("output bit changed while serial clock high");
   a_oe_select: assert property (
      $rose(spi_so_oe) |-> !spi_cs_n)
      else $error("output enabled without select");
endmodule

// file: dv/sfs_host_model.sv
`timescale 1ns/1ns
module sfs_host_model (
   output logic spi_sclk,
   output logic spi_cs_n,
   output logic spi_si,
   input  wire  spi_so
);
   // bits read back, oldest at the upper end
   logic [31:0] rx_r;
   initial begin
      spi_sclk = 1'b0;
      spi_cs_n = 1'b1;
      spi_si = 1'b0;
      rx_r = 32'h0;
   end
   // mode 0 frame, 800 ns clock that stands low outside frames
   task automatic xfer(input logic [15:0] tx, input int ntx,
      input int nrx);
      spi_cs_n = 1'b0;
      for (int i = 0; i < ntx + nrx; i++) begin
         // unused data toggles so a stale level never looks valid
         spi_si = (i < ntx) ? tx[15-i] : ~spi_si;
         #400 spi_sclk = 1'b1;
         if (i >= ntx) rx_r = {rx_r[30:0], spi_so};
         #400 spi_sclk = 1'b0;
      end
      #400 spi_cs_n = 1'b1;
      spi_si = ~spi_si;
      #1600;
   endtask
endmodule

// file: dv/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   typedef struct packed {
      logic [6:0]  in;
      logic [15:0] exp;
   } sfs_row_t;
   logic        mclk, reset, wp_n, busy, write_enable_latch;
   logic        program_suspended, erase_suspended, op_done;
   logic        op_fail, op_aborted, sector_prot_req;
   logic [1:0]  software_protection_summary;
   wire         spi_sclk, spi_cs_n, spi_si, spi_so, spi_so_oe;
   wire         sector_prot_grant, global_prot_go, status_write_end;
   wire         protection_lock, reset_command_enable;
   wire         lockdown_enable, program_erase_error;
   wire  [3:0]  global_prot_code;
   wire  [31:0] rx = sfs_host_model_inst.rx_r;
   int          n_errors = 0;
   int          total_checks = 0;
   int          cycles = 0;
   int          n_go = 0;
   int          n_wend = 0;
   logic [15:0] e0, e1;
   // pins {wp_n,busy,wel,summary,prog susp,erase susp}, then both bytes
   sfs_row_t    rows [4] = '{'{7'h4c, 16'h1c00}, '{7'h36, 16'h0705},
                             '{7'h61, 16'h1103}, '{7'h1b, 16'h0a06}};

   sfs_status_reg sfs_status_reg_inst (.mclk, .reset, .spi_sclk,
      .spi_cs_n, .spi_si, .spi_so, .spi_so_oe, .wp_n, .busy,
      .write_enable_latch, .software_protection_summary,
      .program_suspended, .erase_suspended, .op_done, .op_fail,
      .op_aborted, .sector_prot_req, .sector_prot_grant,
      .global_prot_go, .global_prot_code, .status_write_end,
      .protection_lock, .reset_command_enable, .lockdown_enable,
      .program_erase_error);
   sfs_host_model sfs_host_model_inst (.spi_sclk, .spi_cs_n, .spi_si,
      .spi_so);

   // expected status pair built from the present pin levels
   function automatic logic [15:0] st(input logic l, e, r, s);
      return {l, 1'b0, e, wp_n, software_protection_summary,
         write_enable_latch, busy, 3'h0, r, s, program_suspended,
         erase_suspended, busy};
   endfunction
   task automatic check(input string nm, input logic [31:0] ex, got);
      total_checks++;
      if (got !== ex) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, ex, got);
      end
   endtask
   // four bytes read, so both copies can be compared
   task automatic rd;
      @(negedge mclk);
      sfs_host_model_inst.xfer(16'h0500, 8, 32);
   endtask
   task automatic wr(input logic [15:0] t);
      @(negedge mclk);
      sfs_host_model_inst.xfer(t, 16, 0);
   endtask
   task automatic pulse_req;
      @(negedge mclk) sector_prot_req = 1'b1;
      @(negedge mclk) sector_prot_req = 1'b0;
   endtask
   task automatic opd(input logic f, a);
      @(negedge mclk);
      {op_done, op_fail, op_aborted} = {1'b1, f, a};
      @(negedge mclk) op_done = 1'b0;
      repeat (2) @(negedge mclk);
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   // strobes are one cycle wide and settled at the falling edge
   always @(negedge mclk) begin
      if (global_prot_go === 1'b1) n_go <= n_go + 1;
      if (status_write_end === 1'b1) n_wend <= n_wend + 1;
   end
   // ceiling far above the few thousand cycles the tests need
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         n_errors++;
         finish_test();
      end
   end

   initial begin
      {wp_n, busy, write_enable_latch, software_protection_summary,
         program_suspended, erase_suspended} = 7'h4c;
      {op_done, op_fail, op_aborted, sector_prot_req} = 4'h0;
      reset = 1'b1;
      // two cycles clear every flop, pin synchronisers included
      repeat (2) @(negedge mclk);
      reset = 1'b0;
      check("flags", 32'h0, {protection_lock, reset_command_enable,
         lockdown_enable, program_erase_error, spi_so_oe});
      $display("test reset done");
      foreach (rows[i]) begin
         @(negedge mclk);
         {wp_n, busy, write_enable_latch, software_protection_summary,
            program_suspended, erase_suspended} = rows[i].in;
         rd();
         e0 = rows[i].exp;
         check("byte one", e0[15:8], rx[31:24]);
         check("byte two", e0[7:0], rx[23:16]);
         check("repeat", {e0, e0}, rx);
         check("so enable", 32'h0, spi_so_oe);
      end
      $display("test table done");
      @(negedge mclk);
      {wp_n, busy, write_enable_latch, software_protection_summary,
         program_suspended, erase_suspended} = 7'h5c;
      // lock set freely, then a clear refused while the pin is held
      pulse_req();
      wr(16'h01a4);
      check("lock", 32'h1, protection_lock);
      check("global code", 32'h9, global_prot_code);
      check("global go", 32'h1, n_go);
      pulse_req();
      @(negedge mclk) wp_n = 1'b0;
      wr(16'h0100);
      check("lock held", 32'h1, protection_lock);
      @(negedge mclk) wp_n = 1'b1;
      wr(16'h0100);
      check("lock clear", 32'h0, protection_lock);
      check("no go when locked", 32'h1, n_go);
      // all ones written: only the writable bits may follow
      wr(16'h01ff);
      wr(16'h31ff);
      rd();
      e0 = st(1'b1, 1'b0, 1'b1, 1'b1);
      check("written", {2{e0}}, rx);
      check("global go again", 32'h2, n_go);
      // latch clear, then an unknown opcode: neither may change a bit
      @(negedge mclk) write_enable_latch = 1'b0;
      wr(16'h3100);
      @(negedge mclk) write_enable_latch = 1'b1;
      wr(16'h0200);
      check("refused", 32'h3,
         {reset_command_enable, lockdown_enable});
      check("write ends", 32'h5, n_wend);
      $display("test writes done");
      opd(1'b1, 1'b0);
      check("error", 32'h1, program_erase_error);
      rd();
      e0 = st(1'b1, 1'b1, 1'b1, 1'b1);
      check("error bit", {2{e0}}, rx);
      opd(1'b1, 1'b1);
      check("error abort", 32'h0, program_erase_error);
      $display("test error done");
      // busy rises midway through the first byte 2, after it was loaded and before the repeated byte 1
      e0 = st(1'b1, 1'b0, 1'b1, 1'b1);
      fork
         rd();
         #16000 busy = 1'b1;
      join
      e1 = st(1'b1, 1'b0, 1'b1, 1'b1);
      check("busy", {e0, e1}, rx);
      // deselect in mid-byte: five bits of byte 1, then silence
      @(negedge mclk);
      sfs_host_model_inst.xfer(16'h0500, 8, 5);
      check("part byte", e1[15:11], rx[4:0]);
      check("release", 32'h0, spi_so_oe);
      check("release data", 32'h0, spi_so);
      $display("test busy and release done");
      // a reset in mid-run returns every flag to its power-up value
      @(negedge mclk) reset = 1'b1;
      repeat (2) @(negedge mclk);
      reset = 1'b0;
      check("flags again", 32'h0, {protection_lock, reset_command_enable,
         lockdown_enable, program_erase_error, spi_so_oe});
      $display("test reset again done");
      finish_test();
   end
endmodule

bind sfs_status_reg sfs_monitor sfs_monitor_inst (.mclk, .reset, .spi_sclk,
   .spi_cs_n, .spi_so, .spi_so_oe, .wp_n, .op_done, .op_fail, .op_aborted,
   .sector_prot_req, .sector_prot_grant, .protection_lock,
   .program_erase_error);
